// ==== rtl/jut_defs.vh ====
`ifndef JUT_DEFS_VH
`define JUT_DEFS_VH
// register indices (16-bit register granularity)
`define JUT_IDX_SIZE_LO     7'h3a
`define JUT_IDX_SIZE_HI     7'h3b
`define JUT_IDX_USB_CTL     7'h3c
`define JUT_IDX_ISO_LO      7'h3d
`define JUT_IDX_ISO_HI      7'h3e
`define JUT_IDX_TEST        7'h3f
`define JUT_IDX_LUMA_BASE   7'h40
`define JUT_IDX_CHROMA_BASE 7'h60
`define JUT_IDX_QT_LAST     7'h7f
// field layout of the usb fifo control register
`define JUT_USB_EN_BIT      15
`define JUT_USB_FIFO_HIGH_MARK_MSB      11
`define JUT_USB_FIFO_HIGH_MARK_LSB      8
`define JUT_USB_FIFO_LOW_MARK_MSB      3
`define JUT_USB_FIFO_LOW_MARK_LSB      0
`define JUT_USB_CTL_RESET   16'h0a05
`define JUT_USB_CTL_MASK    16'h8f0f
// high half of 21-bit counts sits in bits 4..0
`define JUT_HI_MASK         16'h001f
`define JUT_HI_W            5
// quantization table depth: 32 luma + 32 chroma words
`define JUT_QT_ENTRIES      64
`define JUT_QT_AW           6
`define JUT_ZERO16          16'h0000
`endif

// ==== rtl/jut_qtable.v ====
`timescale 1ns/100ps
`default_nettype none
`include "jut_defs.vh"
// quantization table storage, luma entries first then chroma
module jut_qtable #(
    parameter DEPTH = `JUT_QT_ENTRIES,
    parameter AW    = `JUT_QT_AW
) (
    // clock
    input  wire          clk,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_idx,
    input  wire [15:0]   wr_data,
    // read port
    input  wire [AW-1:0] rd_idx,
    output wire [15:0]   rd_data
);
    reg [15:0] mem_r [0:DEPTH-1]; // table entries, no reset (undefined at power-on)
    genvar g;
    // one flip-flop word per entry
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : ent
            localparam [AW-1:0] ENT_IDX = g; // entry index at address width
            always @(posedge clk) begin
                if (wr_en && (wr_idx == ENT_IDX)) begin
                    mem_r[g] <= wr_data;
                end
            end
        end
    endgenerate
    // combinational read; the top gates and registers the byte-port result, the encoder lookup passes through ungated
    assign rd_data = mem_r[rd_idx];
endmodule
`default_nettype wire

// ==== rtl/jut_regs.v ====
// Summary of operation
// - report last compressed image size, 21-bit words
// - size low 16 bits, high bits 4..0
// - size registers read-only, undefined after power-on
// - iso pipe runs only when enable bit set
// - high threshold 11..8, low threshold 3..0
// - usb control resets to 0a05 hex
// - 21-bit iso transfer size bounds raw transfers
// - iso size ignored in compressed video mode
// - iso size high bits in bits 4..0
// - qtable reads only while read-enable set; here it gates the byte port only, QT_LOOKUP_DATA is ungated
// - luma table at indices 40..5f hex
// - chroma table at indices 60..7f hex
// - test data register for test mode only
// - register at byte pair twice its index
// - encoder enable bit turns compression on; ENGINE_RUN here also needs ENCODER_CLOCK_ENABLE
`timescale 1ns/100ps
`default_nettype none
`include "jut_defs.vh"
module jut_regs #(
    parameter SIZE_W = 21
) (
    // clock and reset
    input  wire              CLK_SYS,
    input  wire              RST,
    // byte-addressed microcontroller register port (same clock domain)
    input  wire [7:0]        BYTE_ADDR,
    input  wire              BYTE_WR,
    input  wire              BYTE_RD,
    input  wire [7:0]        BYTE_WDATA,
    output reg  [7:0]        BYTE_RDATA,
    // encoder control bits, held in the encoder control register elsewhere
    input  wire              ENCODER_ENABLE,
    input  wire              QTABLE_READ_ENABLE,
    input  wire              ENCODER_CLOCK_ENABLE,
    input  wire              TEST_MODE,
    // compressed image size from the encoder, with its load strobe
    input  wire [SIZE_W-1:0] COMPRESSED_WORD_COUNT,
    input  wire              COUNT_LOAD,
    // usb pipe controls toward the usb fifo logic
    output wire              ISO_PIPE_ENABLE,
    output wire [3:0]        USB_FIFO_HIGH_MARK,
    output wire [3:0]        USB_FIFO_LOW_MARK,
    output wire              ISO_SIZE_VALID,
    output wire [SIZE_W-1:0] ISO_TRANSFER_SIZE,
    // test data toward the test path
    output wire [15:0]       TEST_DATA,
    // encoder engine enable
    output wire              ENGINE_RUN,
    // quantization coefficient lookup by the encoder
    input  wire [5:0]        QT_LOOKUP_IDX,
    output wire [15:0]       QT_LOOKUP_DATA
);
    // decoded register index and byte half
    wire [6:0]  reg_idx = BYTE_ADDR[7:1];
    wire        hi_byte = BYTE_ADDR[0];
    wire        in_qt   = reg_idx[6];                // indices 40..7f
    // registers
    reg [SIZE_W-1:0] img_size_r;                     // last compressed size
    reg [15:0]       usb_ctl_r;                      // enable and thresholds
    reg [15:0]       iso_lo_r;                       // iso size low half
    reg [`JUT_HI_W-1:0] iso_hi_r;                    // iso size high bits
    reg [15:0]       test_r;                         // test data word
    reg [7:0]        wr_lo_hold_r;                   // buffered low byte for qtable
    reg [15:0]       rd_word;                        // selected word for read
    reg [15:0]       wr_word;                        // merged write word
    reg [15:0]       cur_word;                       // current word of target
    wire [15:0]      qt_rd;                          // table read data
    wire             qt_wr;                          // table word write strobe
    // the table is written as a whole word on the high byte, since the
    // table words have no per-byte enable; low byte is staged first
    assign qt_wr = BYTE_WR && in_qt && hi_byte;
    // table storage
    jut_qtable #(
        .DEPTH (`JUT_QT_ENTRIES),
        .AW    (`JUT_QT_AW)
    ) u_qt (
        .clk     (CLK_SYS),
        .wr_en   (qt_wr),
        .wr_idx  (reg_idx[5:0]),
        .wr_data ({BYTE_WDATA, wr_lo_hold_r}),
        .rd_idx  (reg_idx[5:0]),
        .rd_data (qt_rd)
    );
    // second read path for the encoder would need a second port; the
    // encoder reads through a dedicated instance sharing write data
    jut_qtable #(
        .DEPTH (`JUT_QT_ENTRIES),
        .AW    (`JUT_QT_AW)
    ) u_qt_enc (
        .clk     (CLK_SYS),
        .wr_en   (qt_wr),
        .wr_idx  (reg_idx[5:0]),
        .wr_data ({BYTE_WDATA, wr_lo_hold_r}),
        .rd_idx  (QT_LOOKUP_IDX),
        .rd_data (QT_LOOKUP_DATA)
    );
    // current 16-bit contents of each writable register
    always @* begin
        cur_word = `JUT_ZERO16;
        case (reg_idx)
            `JUT_IDX_USB_CTL: begin
                cur_word = usb_ctl_r;
            end
            `JUT_IDX_ISO_LO: begin
                cur_word = iso_lo_r;
            end
            `JUT_IDX_ISO_HI: begin
                cur_word = {11'h000, iso_hi_r};
            end
            `JUT_IDX_TEST: begin
                cur_word = test_r;
            end
            default: begin
                cur_word = `JUT_ZERO16;
            end
        endcase
    end
    // byte merge into the addressed word
    always @* begin
        if (hi_byte) begin
            wr_word = {BYTE_WDATA, cur_word[7:0]};
        end else begin
            wr_word = {cur_word[15:8], BYTE_WDATA};
        end
    end
    // software-writable registers
    always @(posedge CLK_SYS) begin
        if (RST) begin
            usb_ctl_r <= `JUT_USB_CTL_RESET;
        end else if (BYTE_WR && reg_idx == `JUT_IDX_USB_CTL) begin
            usb_ctl_r <= wr_word & `JUT_USB_CTL_MASK; // reserved bits stay zero
        end
    end
    // data registers without a defined reset value
    always @(posedge CLK_SYS) begin
        if (BYTE_WR) begin
            case (reg_idx)
                `JUT_IDX_ISO_LO: begin
                    iso_lo_r <= wr_word;
                end
                `JUT_IDX_ISO_HI: begin
                    iso_hi_r <= wr_word[`JUT_HI_W-1:0]; // upper bits dropped
                end
                `JUT_IDX_TEST: begin
                    test_r <= wr_word;
                end
                default: begin
                    iso_lo_r <= iso_lo_r;
                end
            endcase
            if (in_qt && !hi_byte) begin
                wr_lo_hold_r <= BYTE_WDATA;          // staged table low byte
            end
        end
    end
    // image size capture; writes to these indices are ignored
    always @(posedge CLK_SYS) begin
        if (COUNT_LOAD) begin
            img_size_r <= COMPRESSED_WORD_COUNT;
        end
    end
    // read word select
    always @* begin
        rd_word = `JUT_ZERO16;
        if (in_qt) begin
            // without read-enable the table reads as zero
            if (QTABLE_READ_ENABLE) begin
                rd_word = qt_rd;
            end
        end else begin
            case (reg_idx)
                `JUT_IDX_SIZE_LO: begin
                    rd_word = img_size_r[15:0];
                end
                `JUT_IDX_SIZE_HI: begin
                    rd_word = {11'h000, img_size_r[SIZE_W-1:16]};
                end
                `JUT_IDX_USB_CTL: begin
                    rd_word = usb_ctl_r;
                end
                `JUT_IDX_ISO_LO: begin
                    rd_word = iso_lo_r;
                end
                `JUT_IDX_ISO_HI: begin
                    rd_word = {11'h000, iso_hi_r};
                end
                `JUT_IDX_TEST: begin
                    rd_word = test_r;
                end
                default: begin
                    rd_word = `JUT_ZERO16;           // unmapped reads zero
                end
            endcase
        end
    end
    // registered read byte, valid the cycle after the read strobe
    always @(posedge CLK_SYS) begin
        if (RST) begin
            BYTE_RDATA <= 8'h00;
        end else if (BYTE_RD) begin
            BYTE_RDATA <= hi_byte ? rd_word[15:8] : rd_word[7:0];
        end
    end
    // pipe controls
    assign ISO_PIPE_ENABLE    = usb_ctl_r[`JUT_USB_EN_BIT];
    assign USB_FIFO_HIGH_MARK = usb_ctl_r[`JUT_USB_FIFO_HIGH_MARK_MSB:`JUT_USB_FIFO_HIGH_MARK_LSB];
    assign USB_FIFO_LOW_MARK  = usb_ctl_r[`JUT_USB_FIFO_LOW_MARK_MSB:`JUT_USB_FIFO_LOW_MARK_LSB];
    // iso size bounds raw or still transfers only
    assign ISO_TRANSFER_SIZE  = {iso_hi_r, iso_lo_r};
    assign ISO_SIZE_VALID     = usb_ctl_r[`JUT_USB_EN_BIT] && !ENCODER_ENABLE;
    // test word reaches TEST_DATA only in test mode; the byte port reads it back in any mode
    assign TEST_DATA          = TEST_MODE ? test_r : `JUT_ZERO16;
    // engine runs when enabled and the encoder clock enable is also set
    assign ENGINE_RUN         = ENCODER_ENABLE && ENCODER_CLOCK_ENABLE;
endmodule
`default_nettype wire

// ==== verif/jut_regs_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the register bank
module jut_regs_asserts #(
    parameter SIZE_W = 21
) (
    // clock, reset and byte port
    input wire logic              CLK_SYS, RST, BYTE_WR, BYTE_RD,
    input wire logic [7:0]        BYTE_ADDR, BYTE_WDATA, BYTE_RDATA,
    // control levels
    input wire logic              ENCODER_ENABLE, QTABLE_READ_ENABLE,
    input wire logic              ENCODER_CLOCK_ENABLE, TEST_MODE,
    // outputs under watch
    input wire logic              ENGINE_RUN, ISO_PIPE_ENABLE, ISO_SIZE_VALID,
    input wire logic [3:0]        USB_FIFO_HIGH_MARK, USB_FIFO_LOW_MARK,
    input wire logic [SIZE_W-1:0] ISO_TRANSFER_SIZE,
    input wire logic [15:0]       TEST_DATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    chk_usb_reset: assert property ($fell(RST) |->
        {ISO_PIPE_ENABLE, USB_FIFO_HIGH_MARK, USB_FIFO_LOW_MARK} == 9'h0a5)
        else $error("usb control not at reset value");
    chk_ctl_high: assert property (BYTE_WR && BYTE_ADDR == 8'h79 |=>
        {ISO_PIPE_ENABLE, 3'h0, USB_FIFO_HIGH_MARK} == ($past(BYTE_WDATA) & 8'h8f))
        else $error("pipe enable or high mark not written");
    chk_ctl_low: assert property (BYTE_WR && BYTE_ADDR == 8'h78 |=>
        {4'h0, USB_FIFO_LOW_MARK} == ($past(BYTE_WDATA) & 8'h0f))
        else $error("low mark not written");
    chk_iso_low: assert property (BYTE_WR && BYTE_ADDR == 8'h7a |=>
        ISO_TRANSFER_SIZE[7:0] == $past(BYTE_WDATA)) else $error("iso size low wrong");
    chk_iso_high: assert property (BYTE_WR && BYTE_ADDR == 8'h7c |=>
        {3'h0, ISO_TRANSFER_SIZE[20:16]} == ($past(BYTE_WDATA) & 8'h1f))
        else $error("iso size high wrong");
    chk_iso_valid: assert property (
        ISO_SIZE_VALID == (ISO_PIPE_ENABLE && !ENCODER_ENABLE)) else $error("iso valid wrong");
    chk_engine_run: assert property (
        ENGINE_RUN == (ENCODER_ENABLE && ENCODER_CLOCK_ENABLE)) else $error("run wrong");
    chk_qt_gated: assert property (
        BYTE_RD && BYTE_ADDR[7] && !QTABLE_READ_ENABLE |=> BYTE_RDATA == 8'h00)
        else $error("table read not gated");
    chk_size_rsvd: assert property (BYTE_RD && BYTE_ADDR == 8'h77 |=>
        BYTE_RDATA == 8'h00) else $error("reserved size byte not zero");
    chk_test_quiet: assert property (!TEST_MODE |->
        TEST_DATA == 16'h0000) else $error("test data out of test mode");
endmodule
`default_nettype wire

// ==== verif/jut_uc_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// microcontroller side of the byte register port
module jut_uc_model (
    // clock
    input  wire logic       CLK_SYS,
    // byte port toward the bank
    output var  logic [7:0] BYTE_ADDR,
    output var  logic       BYTE_WR,
    output var  logic       BYTE_RD,
    output var  logic [7:0] BYTE_WDATA,
    input  wire logic [7:0] BYTE_RDATA
);
    // idle at time zero
    initial begin
        BYTE_ADDR = 8'h00;
        BYTE_WR = 1'b0;
        BYTE_RD = 1'b0;
        BYTE_WDATA = 8'h00;
    end
    // one write; data scrambled once released so stale bytes never match
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        BYTE_ADDR <= a;
        BYTE_WDATA <= d;
        BYTE_WR <= 1'b1;
        @(posedge CLK_SYS);
        BYTE_WR <= 1'b0;
        BYTE_WDATA <= ~d;
    endtask
    // one read; data taken after the accepting edge has landed
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] q);
        @(posedge CLK_SYS);
        BYTE_ADDR <= a;
        BYTE_RD <= 1'b1;
        @(posedge CLK_SYS);
        BYTE_RD <= 1'b0;
        @(negedge CLK_SYS);
        q = BYTE_RDATA;
    endtask
endmodule
`default_nettype wire

// ==== verif/jpeg_usb_transfer_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the register bank
module jpeg_usb_transfer_regs_test;
    logic        clk = 1'b0, rst = 1'b1, enc = 1'b0, qtable_read_enable = 1'b0, eck = 1'b0, tm = 1'b0;
    logic        load = 1'b0;
    logic [20:0] cnt = 21'h00_0000, s;
    logic [5:0]  qix = 6'h00;
    logic [15:0] v, r;
    logic [6:0]  qi [6] = '{7'h40, 7'h5f, 7'h60, 7'h7f, 7'h4b, 7'h71};
    wire  [7:0]  adr, wd, rdd;
    wire         wr, rd, pen, sok, run;
    wire  [3:0]  hm, lm;
    wire  [20:0] iso;
    wire  [15:0] td, qd;
    int          err_count = 0, num_checks = 0;
    always #50 clk = ~clk;
    jut_regs u_dut (.CLK_SYS(clk), .RST(rst), .BYTE_ADDR(adr), .BYTE_WR(wr), .BYTE_RD(rd),
        .BYTE_WDATA(wd), .BYTE_RDATA(rdd), .ENCODER_ENABLE(enc), .QTABLE_READ_ENABLE(qtable_read_enable),
        .ENCODER_CLOCK_ENABLE(eck), .TEST_MODE(tm), .COMPRESSED_WORD_COUNT(cnt),
        .COUNT_LOAD(load), .ISO_PIPE_ENABLE(pen), .USB_FIFO_HIGH_MARK(hm),
        .USB_FIFO_LOW_MARK(lm), .ISO_SIZE_VALID(sok), .ISO_TRANSFER_SIZE(iso),
        .TEST_DATA(td), .ENGINE_RUN(run), .QT_LOOKUP_IDX(qix), .QT_LOOKUP_DATA(qd));
    jut_uc_model u_uc (.CLK_SYS(clk), .BYTE_ADDR(adr), .BYTE_WR(wr), .BYTE_RD(rd),
        .BYTE_WDATA(wd), .BYTE_RDATA(rdd));
    // expected high half of a 21-bit count
    function automatic logic [15:0] hi5(input logic [20:0] x);
        return {11'h000, x[20:16]};
    endfunction
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // low byte first, then high byte
    task automatic wr16(input logic [6:0] i, input logic [15:0] d);
        u_uc.wr_byte({i, 1'b0}, d[7:0]);
        u_uc.wr_byte({i, 1'b1}, d[15:8]);
    endtask
    task automatic rd16(input logic [6:0] i, output logic [15:0] q);
        u_uc.rd_byte({i, 1'b0}, q[7:0]);
        u_uc.rd_byte({i, 1'b1}, q[15:8]);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, far beyond the roughly 145 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        v = $urandom(32'h5cb8_28c7);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd16(7'h3c, r);
        check("usb ctl reset", 16'h0a05, r);
        v = $urandom();
        wr16(7'h3c, v);
        rd16(7'h3c, r);
        check("usb ctl", v & 16'h8f0f, r);
        check("usb ports", v & 16'h8f0f, {pen, 3'h0, hm, 4'h0, lm});
        wr16(7'h3c, v | 16'h8000);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            enc <= k[0];
            eck <= k[1];
            @(negedge clk);
            check("run valid", {14'h0, k[0] & k[1], ~k[0]}, {14'h0, run, sok});
        end
        s = $urandom();
        v = $urandom();
        wr16(7'h3d, s[15:0]);
        wr16(7'h3e, {v[15:5], s[20:16]});
        rd16(7'h3e, r);
        check("iso hi", hi5(s), r);
        check("iso port", s[15:0], iso[15:0]);
        check("iso port hi", hi5(s), hi5(iso));
        s = $urandom();
        @(posedge clk);
        cnt <= s;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        cnt <= ~s;
        u_uc.wr_byte(8'h74, ~s[7:0]);
        rd16(7'h3a, r);
        check("size lo", s[15:0], r);
        rd16(7'h3b, r);
        check("size hi", hi5(s), r);
        eck <= 1'b1; // clock enable set before any table access
        foreach (qi[k]) begin
            v = $urandom();
            wr16(qi[k], v);
            @(posedge clk);
            qtable_read_enable <= 1'b0;
            qix <= qi[k][5:0];
            rd16(qi[k], r);
            check("qt gated", 16'h0000, r);
            @(posedge clk);
            qtable_read_enable <= 1'b1;
            rd16(qi[k], r);
            check("qt read", v, r);
            check("qt lookup", v, qd);
        end
        v = $urandom();
        wr16(7'h3f, v);
        @(posedge clk);
        tm <= 1'b1;
        @(negedge clk);
        check("test data", v, td);
        rd16(7'h10, r);
        check("unmapped", 16'h0000, r);
        conclude();
    end
endmodule
bind jut_regs jut_regs_asserts #(.SIZE_W(SIZE_W)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .BYTE_WR(BYTE_WR), .BYTE_RD(BYTE_RD), .BYTE_ADDR(BYTE_ADDR), .BYTE_WDATA(BYTE_WDATA),
    .BYTE_RDATA(BYTE_RDATA), .ENCODER_ENABLE(ENCODER_ENABLE), .TEST_MODE(TEST_MODE),
    .QTABLE_READ_ENABLE(QTABLE_READ_ENABLE), .ENCODER_CLOCK_ENABLE(ENCODER_CLOCK_ENABLE),
    .ENGINE_RUN(ENGINE_RUN), .ISO_PIPE_ENABLE(ISO_PIPE_ENABLE), .ISO_SIZE_VALID(ISO_SIZE_VALID),
    .USB_FIFO_HIGH_MARK(USB_FIFO_HIGH_MARK), .USB_FIFO_LOW_MARK(USB_FIFO_LOW_MARK),
    .ISO_TRANSFER_SIZE(ISO_TRANSFER_SIZE), .TEST_DATA(TEST_DATA));
`default_nettype wire
